//--- hdl/pmw_pkg.sv
// Package: constants and carrier types for the power mode and wakeup controller
package pmw_pkg;

    // ------------------------------------------------------------------
    // Sizes and encodings
    // ------------------------------------------------------------------
    localparam int unsigned EXT_LINES   = 16;
    localparam int unsigned SYNC_STAGES = 2;

    // Low-power target selected by software before the core halts
    typedef enum logic [1:0] {
        PMW_TGT_SLEEP     = 2'h0,
        PMW_TGT_DEEPSLEEP = 2'h1,
        PMW_TGT_STANDBY   = 2'h2
    } pmw_target_t;

    // Boot source picked from the straps
    typedef enum logic [1:0] {
        PMW_BOOT_FLASH  = 2'h0,
        PMW_BOOT_SYSMEM = 2'h1,
        PMW_BOOT_SRAM   = 2'h2
    } pmw_boot_t;

    // System clock source selection
    typedef enum logic [1:0] {
        PMW_CLK_FAST_RC = 2'h0,
        PMW_CLK_CRYSTAL = 2'h1,
        PMW_CLK_PLL     = 2'h2
    } pmw_clksrc_t;

    // Controller states, one-hot
    typedef enum logic [4:0] {
        PMW_ST_RESET     = 5'h01,
        PMW_ST_RUN       = 5'h02,
        PMW_ST_SLEEP     = 5'h04,
        PMW_ST_DEEPSLEEP = 5'h08,
        PMW_ST_STANDBY   = 5'h10
    } pmw_state_t;

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [1:0] BOOT_PIN_DEFAULT = 2'h0;
    localparam int unsigned CLK_PERIOD_PS   = 5000;
    localparam int unsigned RESET_HOLD_NS   = 100;
    localparam int unsigned RESET_HOLD_CYC  =
        (RESET_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0] RESET_HOLD_CNT   = 8'(RESET_HOLD_CYC);

    // Sources that may end deep-sleep besides the external lines
    typedef struct packed {
        logic alarm;
        logic tamper;
        logic timestamp;
        logic comparator;
        logic low_voltage;
        logic serial;
    } pmw_ds_src_t;

    // Sources that may end standby
    typedef struct packed {
        logic ext_reset;
        logic alarm;
        logic watchdog;
        logic wake_pin;
    } pmw_sb_src_t;

    // Clock, oscillator and power controls toward the chip
    typedef struct packed {
        logic        core_clk_en;
        logic        periph_clk_en;
        logic        fast_rc_en;
        logic        crystal_en;
        logic        pll_en;
        logic        regulator_en;
        logic        core_domain_pwr;
        pmw_clksrc_t sys_clk_src;
    } pmw_ctrl_t;

endpackage

//--- hdl/pmw_sync.sv
// Two-stage synchroniser for a bus of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module pmw_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    // Levels
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    // First stage is read only by the second
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;
endmodule
`default_nettype wire

//--- hdl/pmw_edge.sv
// Rising-edge detector for already synchronised levels
`timescale 1ns/1ps
`default_nettype none
module pmw_edge #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    // Level in, pulse out
    input  wire logic [WIDTH-1:0] level_i,
    output logic      [WIDTH-1:0] rise_o
);
    logic [WIDTH-1:0] prev_r;

    // Reset value 1 avoids a false edge on a line already high
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            prev_r <= '1;
        end else begin
            prev_r <= level_i;
        end
    end

    assign rise_o = level_i & ~prev_r;
endmodule
`default_nettype wire

//--- hdl/pmw_ctrl.sv
// Power mode, wakeup, boot and reset controller: top module
// ---------------------------------------------------------------------------
// Overview of operation
// - Sleep stops only the core clock; any interrupt or event resumes run.
// - Deep-sleep stops core-domain clocks, fast RC, crystal and PLL; state kept.
// - Deep-sleep ends on any external line or on-chip wakeup source.
// - Leaving deep-sleep always selects the fast RC as system clock.
// - Standby removes core power, regulator, fast oscillators and PLL.
// - Standby ends only on reset pin, alarm, watchdog, wake pin rise or power-down detect.
// - Boot pins sampled at startup pick flash, loader memory or SRAM.
// - A system reset resets both the core and every peripheral.
// - Reset is held while the supply detector reports low supply.
// - A low-voltage detection raises a warning interrupt to software.
// ---------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module pmw_ctrl
    import pmw_pkg::*;
#(
    parameter int unsigned LINES = EXT_LINES
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              srst_i,
    // Core handshake
    input  wire logic              core_halt_i,
    input  wire pmw_target_t       target_i,
    input  wire logic              irq_pending_i,
    input  wire logic              event_i,
    // Wakeup sources (asynchronous)
    input  wire logic [LINES-1:0]  ext_line_i,
    input  wire pmw_ds_src_t       ds_src_i,
    input  wire logic              external_reset_pin_i,
    input  wire logic              alarm_i,
    input  wire logic              independent_watchdog_i,
    input  wire logic              wakeup_pin_i,
    // Supply supervisors and straps (asynchronous)
    input  wire logic              power_down_detect_i,
    input  wire logic              low_voltage_detector_i,
    input  wire logic [1:0]        boot_pin_i,
    // Clock and power controls
    output pmw_ctrl_t              ctrl_o,
    // Resets and status
    output logic                   core_rst_o,
    output logic                   periph_rst_o,
    output pmw_boot_t              boot_src_o,
    output logic                   lv_irq_o,
    output pmw_state_t             state_o
);
    // ------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------
    if (LINES < 1 || LINES > 32) begin : g_bad_lines
        $error("LINES must be 1 to 32");
    end

    // ------------------------------------------------------------------
    // Synchronisers and edges
    // ------------------------------------------------------------------
    localparam int unsigned NSYNC = LINES + 6 + 4 + 2 + 2;
    logic [NSYNC-1:0] async_all;
    logic [NSYNC-1:0] sync_all;
    logic [LINES-1:0] ext_s;
    pmw_ds_src_t      ds_s;
    logic             external_reset_pin_s;
    logic             alarm_s;
    logic             wdg_s;
    logic             wkp_s;
    logic             pdr_s;
    logic             lvd_s;
    logic [1:0]       boot_s;
    logic             wkp_rise;

    assign async_all = {ext_line_i, ds_src_i, external_reset_pin_i, alarm_i,
                        independent_watchdog_i, wakeup_pin_i, power_down_detect_i,
                        low_voltage_detector_i, boot_pin_i};
    assign {ext_s, ds_s, external_reset_pin_s, alarm_s, wdg_s, wkp_s, pdr_s, lvd_s, boot_s} = sync_all;

    pmw_sync #(.WIDTH(NSYNC)) u_sync (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .async_i (async_all),
        .sync_o  (sync_all)
    );

    // Wake pin counts only on its rising edge
    pmw_edge #(.WIDTH(1)) u_edge (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .level_i (wkp_s),
        .rise_o  (wkp_rise)
    );

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    function automatic pmw_ctrl_t ctrl_for(input pmw_state_t st, input pmw_clksrc_t src);
        pmw_ctrl_t c;
        c = '{core_clk_en: 1'b1, periph_clk_en: 1'b1, fast_rc_en: 1'b1,
              crystal_en: 1'b1, pll_en: 1'b1, regulator_en: 1'b1,
              core_domain_pwr: 1'b1, sys_clk_src: src};
        case (st)
            PMW_ST_SLEEP: begin
                c.core_clk_en = 1'b0;
            end
            PMW_ST_DEEPSLEEP: begin
                c.core_clk_en   = 1'b0;
                c.periph_clk_en = 1'b0;
                c.fast_rc_en    = 1'b0;
                c.crystal_en    = 1'b0;
                c.pll_en        = 1'b0;
            end
            PMW_ST_STANDBY: begin
                c = '0;
            end
            default: begin
            end
        endcase
        return c;
    endfunction

    function automatic pmw_boot_t boot_decode(input logic [1:0] pins);
        case (pins)
            2'h1:    return PMW_BOOT_SYSMEM;
            2'h3:    return PMW_BOOT_SRAM;
            default: return PMW_BOOT_FLASH;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        pmw_state_t  state;
        logic [7:0]  hold_cnt;
        pmw_clksrc_t clk_src;
        pmw_ctrl_t   ctrl;
        logic        core_rst;
        logic        periph_rst;
        pmw_boot_t   boot;
        logic        lv_irq;
        logic        lvd_prev;
    } pmw_regs_t;

    pmw_regs_t st_r;
    pmw_regs_t st_nxt;
    logic      ds_wake;
    logic      sb_wake;
    logic      hold_reset;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // deep-sleep wake set
    assign ds_wake = (|ext_s) | (|ds_s) | irq_pending_i | event_i;
    assign sb_wake = external_reset_pin_s | alarm_s | wdg_s | wkp_rise;
    assign hold_reset = pdr_s;

    always_comb begin
        st_nxt        = st_r;
        st_nxt.lvd_prev = lvd_s;
        st_nxt.lv_irq = lvd_s & ~st_r.lvd_prev;

        if (hold_reset) begin
            st_nxt.state    = PMW_ST_RESET;
            st_nxt.hold_cnt = RESET_HOLD_CNT;
            st_nxt.clk_src  = PMW_CLK_FAST_RC;
        end else begin
            case (st_r.state)
                PMW_ST_RESET: begin
                    if (st_r.hold_cnt != 8'h00) begin
                        st_nxt.hold_cnt = st_r.hold_cnt - 8'h01;
                    end else begin
                        st_nxt.boot  = boot_decode(boot_s);
                        st_nxt.state = PMW_ST_RUN;
                    end
                end
                PMW_ST_RUN: begin
                    if (core_halt_i) begin
                        case (target_i)
                            PMW_TGT_DEEPSLEEP: st_nxt.state = PMW_ST_DEEPSLEEP;
                            PMW_TGT_STANDBY:   st_nxt.state = PMW_ST_STANDBY;
                            default:           st_nxt.state = PMW_ST_SLEEP;
                        endcase
                    end
                end
                PMW_ST_SLEEP: begin
                    if (irq_pending_i | event_i | (|ext_s) | (|ds_s)) begin
                        st_nxt.state = PMW_ST_RUN;
                    end
                end
                PMW_ST_DEEPSLEEP: begin
                    if (ds_wake) begin
                        st_nxt.state   = PMW_ST_RUN;
                        st_nxt.clk_src = PMW_CLK_FAST_RC;
                    end
                end
                PMW_ST_STANDBY: begin
                    // Standby lost all core state, so waking is a full reset
                    if (sb_wake) begin
                        st_nxt.state    = PMW_ST_RESET;
                        st_nxt.hold_cnt = RESET_HOLD_CNT;
                        st_nxt.clk_src  = PMW_CLK_FAST_RC;
                    end
                end
                default: begin
                    st_nxt.state = PMW_ST_RESET;
                end
            endcase
        end

        st_nxt.ctrl = ctrl_for(st_nxt.state, st_nxt.clk_src);
        // one reset for core and peripherals
        st_nxt.core_rst   = (st_nxt.state == PMW_ST_RESET);
        st_nxt.periph_rst = (st_nxt.state == PMW_ST_RESET);
    end

    // ------------------------------------------------------------------
    // Register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_r          <= '0;
            st_r.state    <= PMW_ST_RESET;
            st_r.hold_cnt <= RESET_HOLD_CNT;
            st_r.clk_src  <= PMW_CLK_FAST_RC;
            st_r.ctrl     <= ctrl_for(PMW_ST_RESET, PMW_CLK_FAST_RC);
            st_r.core_rst <= 1'b1;
            st_r.periph_rst <= 1'b1;
            st_r.boot     <= PMW_BOOT_FLASH;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state record
    assign ctrl_o       = st_r.ctrl;
    assign core_rst_o   = st_r.core_rst;
    assign periph_rst_o = st_r.periph_rst;
    assign boot_src_o   = st_r.boot;
    assign lv_irq_o     = st_r.lv_irq;
    assign state_o      = st_r.state;
endmodule
`default_nettype wire

//--- verif/pmw_ctrl_monitor.sv
// Port checker for the power mode controller
`timescale 1ns/1ps
`default_nettype none
module pmw_ctrl_monitor
    import pmw_pkg::*;
#(
    parameter int unsigned LINES = EXT_LINES
) (
    // Clock and reset
    input wire logic             clk_i,
    input wire logic             srst_i,
    // Inputs
    input wire logic             core_halt_i,
    input wire pmw_target_t      target_i,
    input wire logic [LINES-1:0] ext_line_i,
    input wire logic             external_reset_pin_i,
    input wire logic             alarm_i,
    input wire logic             independent_watchdog_i,
    input wire logic             wakeup_pin_i,
    input wire logic             power_down_detect_i,
    input wire logic             low_voltage_detector_i,
    // Outputs
    input wire pmw_ctrl_t        ctrl_o,
    input wire logic             core_rst_o,
    input wire logic             periph_rst_o,
    input wire logic             lv_irq_o,
    input wire pmw_state_t       state_o
);
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // Anything that may end standby or force reset
    wire logic sb_wake = external_reset_pin_i | alarm_i | independent_watchdog_i
        | wakeup_pin_i | power_down_detect_i;
    // Levels held long enough to cross the synchroniser
    sequence s_ds_line;
        (state_o == PMW_ST_DEEPSLEEP && |ext_line_i) [*3];
    endsequence
    sequence s_lv_rise;
        !low_voltage_detector_i ##1 low_voltage_detector_i [*4];
    endsequence
    property p_rst_pair; core_rst_o == periph_rst_o; endproperty
    a_rst_pair: assert property (p_rst_pair) else $error("resets differ");
    property p_sleep; state_o == PMW_ST_SLEEP |-> ctrl_o[8:2] == 7'h3f; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep enables");
    property p_halt_sleep;
        state_o == PMW_ST_RUN && core_halt_i && !power_down_detect_i
            && (target_i == PMW_TGT_SLEEP || target_i == 2'h3) |=> state_o == PMW_ST_SLEEP;
    endproperty
    a_halt_sleep: assert property (p_halt_sleep) else $error("no sleep entry");
    property p_ds_off; state_o == PMW_ST_DEEPSLEEP |-> ctrl_o[8:4] == 5'h0; endproperty
    a_ds_off: assert property (p_ds_off) else $error("deep-sleep enables");
    property p_ds_wake; s_ds_line |-> ##[0:2] state_o != PMW_ST_DEEPSLEEP; endproperty
    a_ds_wake: assert property (p_ds_wake) else $error("no deep-sleep wake");
    property p_ds_exit;
        $past(state_o) == PMW_ST_DEEPSLEEP && state_o == PMW_ST_RUN
            |-> ctrl_o.sys_clk_src == PMW_CLK_FAST_RC;
    endproperty
    a_ds_exit: assert property (p_ds_exit) else $error("clock source");
    property p_sb_off; state_o == PMW_ST_STANDBY |-> ctrl_o[8:2] == 7'h0; endproperty
    a_sb_off: assert property (p_sb_off) else $error("standby enables");
    property p_sb_hold;
        (state_o == PMW_ST_STANDBY && !sb_wake) [*6] |=> state_o == PMW_ST_STANDBY;
    endproperty
    a_sb_hold: assert property (p_sb_hold) else $error("standby left");
    property p_pdr; power_down_detect_i [*6] |-> core_rst_o; endproperty
    a_pdr: assert property (p_pdr) else $error("reset not held");
    property p_lv; s_lv_rise |-> ##[0:2] lv_irq_o; endproperty
    a_lv: assert property (p_lv) else $error("no warning");
endmodule
bind pmw_ctrl pmw_ctrl_monitor #(.LINES(LINES)) u_mon (
    .clk_i(clk_i), .srst_i(srst_i), .core_halt_i(core_halt_i), .target_i(target_i),
    .ext_line_i(ext_line_i), .external_reset_pin_i(external_reset_pin_i),
    .alarm_i(alarm_i), .independent_watchdog_i(independent_watchdog_i),
    .wakeup_pin_i(wakeup_pin_i), .power_down_detect_i(power_down_detect_i),
    .low_voltage_detector_i(low_voltage_detector_i), .ctrl_o(ctrl_o),
    .core_rst_o(core_rst_o), .periph_rst_o(periph_rst_o), .lv_irq_o(lv_irq_o),
    .state_o(state_o)
);
`default_nettype wire

//--- verif/pmw_core_model.sv
// Core model: picks a target, halts, resumes when woken
`timescale 1ns/1ps
`default_nettype none
module pmw_core_model
    import pmw_pkg::*;
(
    // Clock
    input  wire logic        clk_i,
    // Request from the bench
    input  wire logic        req_i,
    input  wire pmw_target_t req_tgt_i,
    // Controller side
    input  wire pmw_state_t  state_i,
    output logic             core_halt_o,
    output pmw_target_t      target_o
);
    // Target set before halt
    // Outside run the target shows junk, as a real core gives no promise
    always @(posedge clk_i) begin
        if (state_i != PMW_ST_RUN) begin
            core_halt_o <= 1'b0;
            target_o    <= pmw_target_t'(~req_tgt_i);
        end else if (req_i && !core_halt_o) begin
            target_o    <= req_tgt_i;
            core_halt_o <= (target_o == req_tgt_i);
        end
    end
endmodule
`default_nettype wire

//--- verif/pmw_ctrl_tb.sv
// Self-checking bench for the power mode and wakeup controller
`timescale 1ns/1ps
`default_nettype none
module pmw_ctrl_tb import pmw_pkg::*;;
    // -------
    // Signals
    // -------
    logic        clk_i = 1'b0;
    logic        srst_i;
    logic        req;
    pmw_target_t req_tgt;
    logic        halt;
    pmw_target_t target;
    logic [27:0] src;
    logic        power_down_detect;
    logic        low_voltage_detector;
    logic [1:0]  boot;
    pmw_ctrl_t   ctrl_o;
    logic        core_rst_o;
    logic        periph_rst_o;
    pmw_boot_t   boot_src_o;
    logic        lv_irq_o;
    pmw_state_t  state_o;
    pmw_state_t  last_st = PMW_ST_RESET;
    pmw_state_t  exp_q[$];
    int          n_fail = 0;
    int          compares = 0;
    int          seed = 32'h53df1d74;
    int          i;
    int          k;
    // Wake sources packed into one vector so loops can index them
    pmw_ctrl DUT (
        .clk_i(clk_i), .srst_i(srst_i), .core_halt_i(halt), .target_i(target),
        .irq_pending_i(src[26]), .event_i(src[27]), .ext_line_i(src[15:0]),
        .ds_src_i(src[21:16]), .external_reset_pin_i(src[22]), .alarm_i(src[23]),
        .independent_watchdog_i(src[24]), .wakeup_pin_i(src[25]),
        .power_down_detect_i(power_down_detect), .low_voltage_detector_i(low_voltage_detector), .boot_pin_i(boot),
        .ctrl_o(ctrl_o), .core_rst_o(core_rst_o), .periph_rst_o(periph_rst_o),
        .boot_src_o(boot_src_o), .lv_irq_o(lv_irq_o), .state_o(state_o)
    );
    pmw_core_model u_core (
        .clk_i(clk_i), .req_i(req), .req_tgt_i(req_tgt), .state_i(state_o),
        .core_halt_o(halt), .target_o(target)
    );
    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;
    // Expected enables, core clock down to domain power
    function automatic logic [6:0] exp_ctrl(input pmw_state_t s);
        logic on;
        logic c;
        logic pw;
        on = (s == PMW_ST_RUN) || (s == PMW_ST_RESET);
        c  = on || (s == PMW_ST_SLEEP);
        pw = (s != PMW_ST_STANDBY);
        return {on, c, c, c, c, pw, pw};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("counts: %0d compares, %0d fails", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Bounded wait; a hang ends the run
    task automatic wait_st(input pmw_state_t s);
        for (int j = 0; j < 200 && state_o !== s; j++) @(posedge clk_i);
        if (state_o !== s) begin
            n_fail++;
            finish_test();
        end else begin
            @(posedge clk_i);
        end
    endtask
    task automatic do_reset(input logic [1:0] b);
        if (last_st != PMW_ST_RESET) exp_q.push_back(PMW_ST_RESET);
        boot <= b;
        srst_i <= 1'b1;
        repeat (16) @(posedge clk_i);
        exp_q.push_back(PMW_ST_RUN);
        srst_i <= 1'b0;
        wait_st(PMW_ST_RUN);
        chk(16'(boot_src_o), (b == 2'h1) ? 16'h1 : (b == 2'h3) ? 16'h2 : 16'h0);
    endtask
    task automatic go(input pmw_target_t t, input pmw_state_t s);
        exp_q.push_back(s);
        req <= 1'b1;
        req_tgt <= t;
        wait_st(s);
        req <= 1'b0;
    endtask
    // Standby wakes through a full reset
    task automatic wake(input int n, input logic sb);
        if (sb) exp_q.push_back(PMW_ST_RESET);
        exp_q.push_back(PMW_ST_RUN);
        src[n] <= 1'b1;
        repeat (4) @(posedge clk_i);
        src[n] <= 1'b0;
        wait_st(PMW_ST_RUN);
    endtask
    // Each state change is matched with the oldest note
    always @(negedge clk_i) begin
        if (state_o !== last_st) begin
            last_st = state_o;
            chk(16'(state_o), (exp_q.size() == 0) ? 16'hffff : 16'(exp_q.pop_front()));
            chk(16'(ctrl_o[8:2]), 16'(exp_ctrl(state_o)));
            chk(16'({core_rst_o, periph_rst_o}), {14'h0, {2{state_o == PMW_ST_RESET}}});
            if (state_o == PMW_ST_RUN) chk(16'(ctrl_o.sys_clk_src), 16'h0);
        end
    end
    initial begin
        srst_i = 1'b1;
        req = 1'b0;
        req_tgt = PMW_TGT_SLEEP;
        src = '0;
        power_down_detect = 1'b0;
        low_voltage_detector = 1'b0;
        boot = 2'h0;
        for (i = 0; i < 4; i++) do_reset(2'(i));
        $display("test boot done");
        // Sleep wakes on interrupt, event, a line, an on-chip source
        for (i = 0; i < 4; i++) begin
            k = (i < 2) ? 26 + i : 16 * (i - 2) + $unsigned($random(seed)) % 6;
            go(i[0] ? pmw_target_t'(2'h3) : PMW_TGT_SLEEP, PMW_ST_SLEEP);
            wake(k, 1'b0);
        end
        $display("test sleep done");
        // Every line and on-chip source ends deep-sleep
        for (i = 0; i < 22; i++) begin
            go(PMW_TGT_DEEPSLEEP, PMW_ST_DEEPSLEEP);
            wake(i, 1'b0);
        end
        $display("test deep-sleep done");
        // Lines and interrupts ignored, four sources wake
        for (i = 22; i < 26; i++) begin
            go(PMW_TGT_STANDBY, PMW_ST_STANDBY);
            k = $unsigned($random(seed)) % 22;
            src[k] <= 1'b1;
            src[26] <= 1'b1;
            repeat (6) @(posedge clk_i);
            src[k] <= 1'b0;
            src[26] <= 1'b0;
            repeat (10) @(posedge clk_i);
            wake(i, 1'b1);
        end
        $display("test standby done");
        exp_q.push_back(PMW_ST_RESET);
        exp_q.push_back(PMW_ST_RUN);
        power_down_detect <= 1'b1;
        repeat (40) @(posedge clk_i);
        chk(16'(core_rst_o), 16'h1);
        power_down_detect <= 1'b0;
        wait_st(PMW_ST_RUN);
        $display("test supply done");
        low_voltage_detector <= 1'b1;
        k = 0;
        repeat (12) begin
            @(posedge clk_i);
            k += (lv_irq_o === 1'b1);
        end
        chk(16'(k), 16'h1);
        low_voltage_detector <= 1'b0;
        $display("test warning done");
        chk(16'(exp_q.size()), 16'h0);
        finish_test();
    end
endmodule
`default_nettype wire
